// File: core/eui_top.sv
`default_nettype none
module eui_top
  import eui_pkg::*;
#(
  parameter int ADDR_W = eui_pkg::ADDR_W
) (
  input  wire logic                       pclk,     // system clock
  input  wire logic                       presetn,  // async reset, active low
  input  wire logic [ADDR_W-1:0]          paddr,    // apb byte address
  input  wire logic                       psel,     // apb select
  input  wire logic                       penable,  // apb access phase
  input  wire logic                       pwrite,   // apb direction
  input  wire logic [eui_pkg::DATA_W-1:0] pwdata,   // apb write data
  input  wire logic [3:0]                 pstrb,    // apb byte strobes
  output logic [eui_pkg::DATA_W-1:0]      prdata,   // apb read data
  output logic                            pready,   // apb ready
  output logic                            pslverr,  // apb error, unmapped
  input  wire logic [7:0]                 edge_in,  // edge sources
  input  wire logic [eui_pkg::NUM_CH-1:0] rxd,      // serial inputs
  output logic [eui_pkg::NUM_CH-1:0]      txd,      // serial outputs
  output logic                            irq       // interrupt request
);
  import eui_pkg::*;

  // write-one clear; a set in the same cycle wins
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic clr, input logic [7:0] d,
                                     input logic [7:0] set);
    w1c = (cur & ~(clr ? d : 8'h00)) | set;
  endfunction

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hits = (a == byte_addr(idx));
  endfunction

  // registers
  logic [7:0]       edge_flags_r;
  logic [7:0]       edge_mask_r;
  logic [7:0]       serial_irq_flags_r;
  logic [7:0]       serial_irq_enables_r;
  logic [TMR_W-1:0] tmr3_r;
  logic [TMR_W-1:0] tmr4_r;
  logic [7:0]       ctrl_r     [NUM_CH];
  logic [7:0]       edge_prev_r;

  // channel state
  logic [7:0]       tx_data_r  [NUM_CH];
  logic [9:0]       tx_shift_r [NUM_CH];
  logic [3:0]       tx_bit_r   [NUM_CH];
  logic [3:0]       tx_sub_r   [NUM_CH];
  logic [NUM_CH-1:0] tx_full_r;
  logic [NUM_CH-1:0] tx_busy_r;
  logic [NUM_CH-1:0] tx_cond_prev_r;
  logic [7:0]       rx_shift_r [NUM_CH];
  logic [7:0]       rx_data_r  [NUM_CH];
  logic [3:0]       rx_bit_r   [NUM_CH];
  logic [3:0]       rx_sub_r   [NUM_CH];
  logic [NUM_CH-1:0] rx_act_r;
  logic [NUM_CH-1:0] rx_full_r;
  logic [NUM_CH-1:0] rx_ovr_r;
  logic [NUM_CH-1:0] rx_done_r;

  logic             t3_tick;
  logic             t4_tick;
  logic [NUM_CH-1:0] tick16;
  logic [NUM_CH-1:0] tx_cond;
  logic [NUM_CH-1:0] data_wr;
  logic [NUM_CH-1:0] data_rd;
  logic [NUM_CH-1:0] ctrl_wr;
  logic [7:0]       edge_hit;
  logic [7:0]       ser_set;
  logic             wr_fire;
  logic             rd_fire;
  logic             wr_lo;
  logic [7:0]       rd_mux;
  logic             mapped;

  eui_rate_timer #(.TMR_W(TMR_W)) u_tmr3 (
    .pclk    (pclk),
    .presetn (presetn),
    .reload  (tmr3_r),
    .tick    (t3_tick)
  );

  eui_rate_timer #(.TMR_W(TMR_W)) u_tmr4 (
    .pclk    (pclk),
    .presetn (presetn),
    .reload  (tmr4_r),
    .tick    (t4_tick)
  );

  // apb decode
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;
  assign wr_lo   = wr_fire & pstrb[0];

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      tick16[c]  = ctrl_r[c][CTRL_TMR_SEL] ? t4_tick : t3_tick;
      data_wr[c] = wr_lo & hits(paddr, IDX_DATA_BASE + 16'(c));
      data_rd[c] = rd_fire & hits(paddr, IDX_DATA_BASE + 16'(c));
      ctrl_wr[c] = wr_lo & hits(paddr, IDX_CTRL_BASE + 16'(c));
      // data empty alone, or data and shift empty
      tx_cond[c] = ctrl_r[c][CTRL_TX_EN] &
                   (ctrl_r[c][CTRL_TX_SEL] ? (~tx_full_r[c] & ~tx_busy_r[c]) : ~tx_full_r[c]);
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    mapped = 1'b1;
    if (hits(paddr, IDX_EDGE_FLAGS))      rd_mux = edge_flags_r;
    else if (hits(paddr, IDX_EDGE_MASK))  rd_mux = edge_mask_r;
    else if (hits(paddr, IDX_SER_FLAGS))  rd_mux = serial_irq_flags_r;
    else if (hits(paddr, IDX_SER_EN))     rd_mux = serial_irq_enables_r;
    else if (hits(paddr, IDX_TMR3))       rd_mux = 8'h00;
    else if (hits(paddr, IDX_TMR4))       rd_mux = 8'h00;
    else mapped = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (hits(paddr, IDX_CTRL_BASE + 16'(c))) begin
        rd_mux = ctrl_r[c] & CTRL_WR_MASK;
        rd_mux[CTRL_TX_EMPTY] = ~tx_full_r[c];
        rd_mux[CTRL_RX_FULL]  = rx_full_r[c];
        rd_mux[CTRL_OVR]      = rx_ovr_r[c];
        mapped = 1'b1;
      end
      if (hits(paddr, IDX_DATA_BASE + 16'(c))) begin
        rd_mux = rx_data_r[c];
        mapped = 1'b1;
      end
    end
  end

  // answer in the access cycle right after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        if (hits(paddr, IDX_TMR3))      prdata <= DATA_W'(tmr3_r);
        else if (hits(paddr, IDX_TMR4)) prdata <= DATA_W'(tmr4_r);
        else                            prdata <= DATA_W'(rd_mux);
      end
    end
  end

  // plain read/write registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_irq_enables_r <= RST_SER_EN;
      edge_mask_r          <= RST_EDGE_MASK;
      tmr3_r               <= RST_TMR;
      tmr4_r               <= RST_TMR;
      for (int c = 0; c < NUM_CH; c++) ctrl_r[c] <= RST_CTRL;
    end else if (wr_fire) begin
      if (pstrb[0] & hits(paddr, IDX_SER_EN))    serial_irq_enables_r <= pwdata[7:0];
      if (pstrb[0] & hits(paddr, IDX_EDGE_MASK)) edge_mask_r <= pwdata[7:0];
      if (hits(paddr, IDX_TMR3)) begin
        if (pstrb[0]) tmr3_r[7:0]  <= pwdata[7:0];
        if (pstrb[1]) tmr3_r[15:8] <= pwdata[15:8];
      end
      if (hits(paddr, IDX_TMR4)) begin
        if (pstrb[0]) tmr4_r[7:0]  <= pwdata[7:0];
        if (pstrb[1]) tmr4_r[15:8] <= pwdata[15:8];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (ctrl_wr[c]) ctrl_r[c] <= pwdata[7:0] & CTRL_WR_MASK;
      end
    end
  end

  // edge detection; reset value suppresses a false first edge
  always_comb begin
    edge_hit = (edge_in & ~edge_prev_r & EDGE_RISING) | (~edge_in & edge_prev_r & ~EDGE_RISING);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) edge_prev_r <= EDGE_RISING;
    else          edge_prev_r <= edge_in;
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ser_set[2*c+SER_TX_OFS] = tx_cond[c] & ~tx_cond_prev_r[c];
      ser_set[2*c+SER_RX_OFS] = rx_done_r[c];
    end
  end

  // sticky flags, set beats write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_flags_r       <= RST_FLAGS;
      serial_irq_flags_r <= RST_FLAGS;
      tx_cond_prev_r     <= '0;
    end else begin
      tx_cond_prev_r <= tx_cond;
      edge_flags_r       <= w1c(edge_flags_r, wr_lo & hits(paddr, IDX_EDGE_FLAGS), pwdata[7:0], edge_hit);
      serial_irq_flags_r <= w1c(serial_irq_flags_r, wr_lo & hits(paddr, IDX_SER_FLAGS), pwdata[7:0], ser_set);
    end
  end

  // request regardless of how flags latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else          irq <= |(edge_flags_r & edge_mask_r) | |(serial_irq_flags_r & serial_irq_enables_r);
  end

  // transmitters, 8 data bits and one stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_full_r <= '0;
      tx_busy_r <= '0;
      txd       <= '1;
      for (int c = 0; c < NUM_CH; c++) begin
        tx_data_r[c]  <= 8'h00;
        tx_shift_r[c] <= 10'h3ff;
        tx_bit_r[c]   <= 4'h0;
        tx_sub_r[c]   <= 4'h0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        txd[c] <= tx_busy_r[c] ? tx_shift_r[c][0] : 1'b1;
        if (!ctrl_r[c][CTRL_TX_EN]) begin
          tx_busy_r[c] <= 1'b0;
        end else if (!tx_busy_r[c]) begin
          if (tx_full_r[c] && tick16[c]) begin
            tx_shift_r[c] <= {1'b1, tx_data_r[c], 1'b0};
            tx_busy_r[c]  <= 1'b1;
            tx_full_r[c]  <= 1'b0;
            tx_bit_r[c]   <= 4'h0;
            tx_sub_r[c]   <= 4'h0;
          end
        end else if (tick16[c]) begin
          tx_sub_r[c] <= tx_sub_r[c] + 4'h1;
          if (tx_sub_r[c] == 4'(OVERSAMPLE - 1)) begin
            tx_shift_r[c] <= {1'b1, tx_shift_r[c][9:1]};
            tx_bit_r[c]   <= tx_bit_r[c] + 4'h1;
            if (tx_bit_r[c] == 4'(TX_FRAME_BITS - 1)) tx_busy_r[c] <= 1'b0;
          end
        end
        if (data_wr[c]) begin
          tx_data_r[c] <= pwdata[7:0];
          tx_full_r[c] <= 1'b1;
        end
      end
    end
  end

  // receivers, start bit qualified at mid point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_act_r  <= '0;
      rx_full_r <= '0;
      rx_ovr_r  <= '0;
      rx_done_r <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        rx_shift_r[c] <= 8'h00;
        rx_data_r[c]  <= 8'h00;
        rx_bit_r[c]   <= 4'h0;
        rx_sub_r[c]   <= 4'h0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        rx_done_r[c] <= 1'b0;
        if (data_rd[c]) rx_full_r[c] <= 1'b0;
        if (ctrl_wr[c] && pwdata[CTRL_OVR]) rx_ovr_r[c] <= 1'b0;
        if (!ctrl_r[c][CTRL_RX_EN]) begin
          rx_act_r[c] <= 1'b0;
          rx_sub_r[c] <= 4'h0;
        end else if (tick16[c]) begin
          if (!rx_act_r[c]) begin
            if (!rxd[c]) begin
              rx_sub_r[c] <= rx_sub_r[c] + 4'h1;
              if (rx_sub_r[c] == 4'(RX_MID_SAMPLE)) begin
                rx_act_r[c] <= 1'b1;
                rx_sub_r[c] <= 4'h0;
                rx_bit_r[c] <= 4'h0;
              end
            end else begin
              rx_sub_r[c] <= 4'h0;
            end
          end else begin
            rx_sub_r[c] <= rx_sub_r[c] + 4'h1;
            if (rx_sub_r[c] == 4'(OVERSAMPLE - 1)) begin
              rx_bit_r[c] <= rx_bit_r[c] + 4'h1;
              if (rx_bit_r[c] < 4'(RX_DATA_BITS)) begin
                rx_shift_r[c] <= {rxd[c], rx_shift_r[c][7:1]};
              end else begin
                rx_act_r[c]  <= 1'b0;
                rx_sub_r[c]  <= 4'h0;
                rx_data_r[c] <= rx_shift_r[c];
                rx_full_r[c] <= 1'b1;
                rx_done_r[c] <= 1'b1;
                if (rx_full_r[c] && !data_rd[c]) rx_ovr_r[c] <= 1'b1;
              end
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: core/eui_pkg.sv
// How it works
// - an eight-bit edge flag register latches one flag per edge source, reads 1 once hit, and a 1 written clears it.
// - an eight-bit serial enable register holds transmit/receive enables of channels 3..0 from bit 7 down.
// - an eight-bit serial flag register uses the same layout, sets on the event, clears on a written 1, resets to 0.
// - four independent full-duplex asynchronous serial channels, each with a programmable rate from one of two shared timers.
// - each channel is run through its own control and status register.
// - each channel takes its rate from timer 3 or timer 4, as its control register selects.
// - bit rates up to half a megabit per second at an eight megahertz clock are supported.
// - transmitter and receiver of each channel are enabled and disabled separately.
// - the bit rate is the selected timer's output rate divided by sixteen.
// - the receive flag sets each time a finished character moves into the receive data register.
// - a control bit picks the transmit condition: data register empty, or data and shift register empty.
`default_nettype none
package eui_pkg;
  localparam int          NUM_CH         = 4;
  localparam int          ADDR_W         = 18;
  localparam int          DATA_W         = 32;
  localparam int          TMR_W          = 16;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_EDGE_MASK  = 16'hdf4a;
  localparam logic [15:0] IDX_EDGE_FLAGS = 16'hdf47;
  localparam logic [15:0] IDX_SER_FLAGS  = 16'hdf48;
  localparam logic [15:0] IDX_SER_EN     = 16'hdf49;
  localparam logic [15:0] IDX_TMR3       = 16'hdf4c;
  localparam logic [15:0] IDX_TMR4       = 16'hdf4d;
  localparam logic [15:0] IDX_CTRL_BASE  = 16'hdf50;
  localparam logic [15:0] IDX_DATA_BASE  = 16'hdf58;
  // reset values
  localparam logic [7:0]  RST_FLAGS      = 8'h00;
  localparam logic [7:0]  RST_SER_EN     = 8'h00;
  localparam logic [7:0]  RST_EDGE_MASK  = 8'h00;
  localparam logic [7:0]  RST_CTRL       = 8'h00;
  localparam logic [TMR_W-1:0] RST_TMR   = 16'h0000;
  // edge sources: 1 = rising edge sets the flag, 0 = falling edge
  localparam logic [7:0]  EDGE_RISING    = 8'h4d;
  // serial flag/enable layout: channel c has tx at 2c+1, rx at 2c
  localparam int          SER_TX_OFS     = 1;
  localparam int          SER_RX_OFS     = 0;
  // control and status bits of a channel
  localparam int          CTRL_TX_EN     = 0;
  localparam int          CTRL_TX_SEL    = 1;
  localparam int          CTRL_TMR_SEL   = 2;
  localparam int          CTRL_TX_EMPTY  = 4;
  localparam int          CTRL_RX_EN     = 5;
  localparam int          CTRL_RX_FULL   = 6;
  localparam int          CTRL_OVR       = 7;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'h27;
  // character framing
  localparam int          OVERSAMPLE     = 16;
  localparam int          TX_FRAME_BITS  = 10;
  localparam int          RX_DATA_BITS   = 8;
  localparam int          RX_MID_SAMPLE  = 7;
  // fastest documented rate and the clock it needs
  localparam int          MAX_BPS        = 500000;
  localparam int          REF_FCLK_HZ    = 8000000;
  localparam int          PCLK_HZ        = 100000000;
endpackage
`default_nettype wire

// File: core/eui_rate_timer.sv
`default_nettype none
module eui_rate_timer #(
  parameter int TMR_W = 16
) (
  input  wire logic             pclk,    // system clock
  input  wire logic             presetn, // async reset, active low
  input  wire logic [TMR_W-1:0] reload,  // divisor minus one
  output logic                  tick     // one pulse each reload+1 cycles
);
  logic [TMR_W-1:0] cnt_r;

  // period is reload+1 cycles, so N = fclk/(16*bps)-1 gives the rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r <= reload;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: dv/eui_assertions.sv
`default_nettype none
module eui_assertions
  import eui_pkg::*;
#(
  parameter int ADDR_W = eui_pkg::ADDR_W
) (
  input wire logic              pclk,    // clock
  input wire logic              presetn, // reset, active low
  input wire logic [ADDR_W-1:0] paddr,   // apb address
  input wire logic              psel,    // apb select
  input wire logic              penable, // apb access
  input wire logic              pwrite,  // apb direction
  input wire logic [31:0]       pwdata,  // apb write data
  input wire logic [3:0]        pstrb,   // apb strobes
  input wire logic [31:0]       prdata,  // apb read data
  input wire logic              pready,  // apb ready
  input wire logic              pslverr, // apb error
  input wire logic [7:0]        edge_in, // edge sources
  input wire logic              irq      // interrupt request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] prev_r;
  logic [7:0] ef_r;
  logic [7:0] em_r;
  logic       wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_r <= EDGE_RISING;
    else prev_r <= edge_in;
  end
  // shadow of the edge flags: set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ef_r <= 8'h00;
    else ef_r <= (ef_r & ~((wr && paddr == {IDX_EDGE_FLAGS, 2'b00}) ? pwdata[7:0] : 8'h00))
                 | (EDGE_RISING & edge_in & ~prev_r) | (~EDGE_RISING & prev_r & ~edge_in);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) em_r <= 8'h00;
    else if (wr && paddr == {IDX_EDGE_MASK, 2'b00}) em_r <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  apb_wait_a: assert property (s_setup |=> s_access) else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  ready_once_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("error read not zero");
  upper_zero_a: assert property (s_access and !pwrite |-> prdata[31:16] == 16'h0) else $error("upper bits set");
  edge_irq_a: assert property (|(ef_r & em_r) |=> irq) else $error("edge flag gave no request");
  reset_quiet_a: assert property ($rose(presetn) |-> !irq) else $error("request right after reset");
endmodule
bind eui_top eui_assertions #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .edge_in, .irq);
`default_nettype wire

// File: dv/eui_far_side.sv
`default_nettype none
module eui_far_side (
  input  wire logic       pclk,    // clock
  input  wire logic [3:0] txd,     // serial lines from the block
  output var  logic [7:0] edge_in, // edge pins
  output var  logic [3:0] rxd      // serial lines into the block
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    edge_in = 8'h00;
    rxd     = 4'hf;
  end
  // one cycle high: exactly one rising and one falling edge
  task automatic pulse(input int b);
    edge_in[b] <= 1'b1;
    @(posedge pclk);
    edge_in[b] <= 1'b0;
  endtask
  task automatic send(input int c, input logic [7:0] d, input int per);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd[c] <= f[i];
      repeat (per) @(posedge pclk);
    end
  endtask
  task automatic recv(input int c, input int per, output logic [7:0] d);
    int n;
    n = 0;
    while (txd[c] !== 1'b0 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    repeat (per / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (per) @(negedge pclk);
      d[i] = txd[c];
    end
  endtask
endmodule
`default_nettype wire

// File: dv/edge_uart_irq_flags_and_rate_bench.sv
`default_nettype none
module edge_uart_irq_flags_and_rate_bench;
  import eui_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, rxd, txd;
  logic [7:0]  edge_in, ef, em, v, w, got;
  logic [15:0] ridx[3];
  int          miscompares, cmp_count, b, per;
  eui_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
               .pslverr, .edge_in, .rxd, .txd, .irq);
  eui_far_side far (.pclk, .txd, .edge_in, .rxd);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wn, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    n = 0;
    psel   <= 1'b1;
    pwrite <= wn;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    results();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    ef = 8'h00;
    ridx = '{IDX_EDGE_FLAGS, IDX_SER_FLAGS, IDX_SER_EN};
    void'($urandom(47));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("irq", 0, irq);
    foreach (ridx[i]) begin
      xfer(0, ridx[i], 0);
      chk("reset value", 0, rd);
      chk("mapped error", 0, er);
    end
    xfer(0, 16'h0123, 0);
    chk("unmapped", 1, er);
    v = 8'($urandom);
    xfer(1, IDX_SER_EN, v);
    pstrb <= 4'he;
    xfer(1, IDX_SER_EN, ~v);
    pstrb <= 4'hf;
    xfer(0, IDX_SER_EN, 0);
    chk("serial enables", v, rd);
    em = 8'($urandom);
    xfer(1, IDX_EDGE_MASK, em);
    for (int i = 0; i < 16; i++) begin
      b = $urandom_range(7, 0);
      @(posedge pclk);
      far.pulse(b);
      ef[b] = 1'b1;
      repeat (3) @(negedge pclk);
      chk("irq", |(ef & em), irq);
      xfer(0, IDX_EDGE_FLAGS, 0);
      chk("edge flags", ef, rd);
      if (i % 4 == 3) begin
        v = 8'($urandom) | (8'h01 << b);
        fork
          xfer(1, IDX_EDGE_FLAGS, v);
          begin
            repeat (2) @(posedge pclk);
            far.pulse(b);
          end
        join
        ef = (ef & ~v) | (8'h01 << b);
      end
    end
    xfer(1, IDX_EDGE_FLAGS, 8'hff);
    xfer(1, IDX_TMR3, 0);
    xfer(1, IDX_TMR4, 1);
    xfer(0, IDX_TMR4, 0);
    chk("timer4 reload", 1, rd);
    for (int c = 0; c < 4; c++) begin
      per = (c % 2) ? 32 : 16;
      xfer(1, IDX_SER_EN, 8'h01 << (2 * c));
      xfer(1, 16'(IDX_CTRL_BASE + c), 32'(8'h20 + 4 * (c % 2) + (c < 3 ? 1 : 0)));
      repeat (4) @(posedge pclk);
      xfer(0, IDX_SER_FLAGS, 0);
      chk("tx flag", (c < 3) ? (32'h2 << (2 * c)) : 32'h0, rd);
      xfer(1, IDX_SER_FLAGS, 8'hff);
      v = 8'($urandom);
      far.send(c, v, per);
      repeat (per) @(negedge pclk);
      chk("irq", 1, irq);
      xfer(0, IDX_SER_FLAGS, 0);
      chk("rx flag", 32'h1 << (2 * c), rd);
      xfer(0, 16'(IDX_DATA_BASE + c), 0);
      chk("rx data", v, rd);
      xfer(1, IDX_SER_FLAGS, 8'hff);
      repeat (2) @(negedge pclk);
      chk("irq", 0, irq);
      if (c < 3) begin
        w = 8'($urandom);
        fork
          far.recv(c, per, got);
          xfer(1, 16'(IDX_DATA_BASE + c), w);
        join
        chk("tx data", w, got);
      end
      repeat (2 * per) @(posedge pclk);
      xfer(1, IDX_SER_FLAGS, 8'hff);
    end
    // transmit flag waits for data and shift register both empty
    xfer(1, IDX_CTRL_BASE, 32'h23);
    xfer(1, IDX_SER_EN, 8'h02);
    xfer(1, IDX_SER_FLAGS, 8'hff);
    w = 8'($urandom);
    fork
      far.recv(0, 16, got);
      begin
        xfer(1, IDX_DATA_BASE, w);
        repeat (40) @(posedge pclk);
        xfer(0, IDX_SER_FLAGS, 0);
        chk("tx flag busy", 0, rd);
        chk("irq busy", 0, irq);
      end
    join
    repeat (40) @(posedge pclk);
    xfer(0, IDX_SER_FLAGS, 0);
    chk("tx flag idle", 32'h2, rd);
    chk("irq tx", 1, irq);
    chk("tx data sel", w, got);
    results();
  end
endmodule
`default_nettype wire
